//--- sbt_jtag_host.sv
`timescale 1ns/1ps
// Model of the external test controller; its clock stands low between frames
module sbt_jtag_host (
  // Test link
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One link cycle; tdo is read just before the rise, settled since the fall
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6;
    o = tdo;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask

  // Mode steps taken lowest bit first
  task automatic moves(input logic [7:0] path, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      tick(path[i], 1'b0, o);
    end
  endtask

  // Mode held high resets the controller
  task automatic tapReset(input int n);
    moves(8'hFF, n);
  endtask

  // Idle to capture, n shifts, update and back to idle
  task automatic scan(input logic ir, input int n, input logic [79:0] din,
                      output logic [79:0] dout);
    dout = '0;
    moves(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i]);
    end
    moves(8'h01, 2);
    // Released data line shows the inverse, not a stale level
    tdi = ~tdi;
  endtask
endmodule

//--- sbt_support.sv
`timescale 1ns/1ps
package sbt_pkg;
  // Instruction codes held in the instruction register
  localparam logic [2:0] IR_RING_HIZ   = 3'h0;
  localparam logic [2:0] IR_IDENT      = 3'h1;
  localparam logic [2:0] IR_SAMPLE_HIZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE     = 3'h4;
  localparam logic [2:0] IR_SKIP       = 3'h7;
  localparam logic [2:0] IR_CAPTURE    = 3'h1;
  localparam logic [2:0] IR_RESET      = 3'h1;
  localparam int         IR_WIDTH      = 3;

  // Register lengths
  localparam int CHAIN_WIDE   = 70;
  localparam int CHAIN_NARROW = 51;
  localparam int CHAIN_MAX    = 70;
  localparam int ID_WIDTH     = 32;

  // Identity word field positions
  localparam int ID_REV_LSB    = 28;
  localparam int ID_DEPTH_LSB  = 23;
  localparam int ID_WIDTH_LSB  = 18;
  localparam int ID_DEV_LSB    = 12;
  localparam int ID_VENDOR_LSB = 1;
  localparam logic ID_PRESENT  = 1'b1;

  // Test access port controller states
  typedef enum logic [3:0] {
    ST_EX2DR = 4'h0, ST_EX1DR = 4'h1, ST_SHDR  = 4'h2, ST_PDR   = 4'h3,
    ST_SELIR = 4'h4, ST_UPDDR = 4'h5, ST_CAPDR = 4'h6, ST_SELDR = 4'h7,
    ST_EX2IR = 4'h8, ST_EX1IR = 4'h9, ST_SHIR  = 4'hA, ST_PIR   = 4'hB,
    ST_RTI   = 4'hC, ST_UPDIR = 4'hD, ST_CAPIR = 4'hE, ST_TLR   = 4'hF
  } sbt_state_e;
endpackage

// Two-flop synchroniser for levels entering a clock domain
module sbt_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input  wire logic             clk,
  input  wire logic             rstn,
  // Level from the other domain
  input  wire logic [WIDTH-1:0] din,
  // Level safe to use in this domain
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second one
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

//--- sbt_tap.sv
`timescale 1ns/1ps
module sbt_tap #(
  parameter int         CHAIN_LEN  = sbt_pkg::CHAIN_WIDE,
  parameter logic [3:0] REV_CODE   = 4'h0, // Arbitrary value
  parameter logic [4:0] DEPTH_CODE = 5'h0A, // Arbitrary value
  parameter logic [4:0] WIDTH_CODE = 5'h05, // Arbitrary value
  parameter logic [5:0] DEV_CODE   = 6'h00, // Arbitrary value
  parameter logic [10:0] VENDOR    = 11'h2A5 // Arbitrary value
) (
  // Memory clock domain
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  // Test link, on its own clock
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdoOen,
  // Memory pin ring and output control, memory clock domain
  input  wire logic [CHAIN_LEN-1:0] ringIn,
  output logic                      memOutputsOff
);
  localparam logic [31:0] ID_WORD = {REV_CODE, DEPTH_CODE, WIDTH_CODE, DEV_CODE, VENDOR,
                                     sbt_pkg::ID_PRESENT};

  typedef struct packed {
    sbt_pkg::sbt_state_e           st;
    logic [sbt_pkg::IR_WIDTH-1:0]  ir;
    logic [sbt_pkg::IR_WIDTH-1:0]  irShift;
    logic [sbt_pkg::CHAIN_MAX-1:0] dr;
    logic                          skip;
    logic                          outOff;
  } sbt_tck_s;

  sbt_tck_s                 r;
  sbt_tck_s                 next_r;
  logic                     tapRstn;
  logic [CHAIN_LEN-1:0]     ringSync;
  logic                     serialOut;
  logic                     selRing;
  logic [6:0]               insIdx;

  // Reset released into the link domain through two flops
  sbt_sync #(.WIDTH(1)) u_rst_sync (
    .clk  (tck),
    .rstn (1'b1),
    .din  (resetn),
    .dout (tapRstn)
  );

  // Pin ring is sampled from the memory domain; it may still move while captured
  sbt_sync #(.WIDTH(CHAIN_LEN)) u_ring_sync (
    .clk  (tck),
    .rstn (tapRstn),
    .din  (ringIn),
    .dout (ringSync)
  );

  // Float request crosses back as a level
  sbt_sync #(.WIDTH(1)) u_off_sync (
    .clk  (core_clk),
    .rstn (resetn),
    .din  (r.outOff),
    .dout (memOutputsOff)
  );

  // Which data path is between data in and data out; reserved codes fall to skip
  always_comb begin
    selRing = (r.ir == sbt_pkg::IR_RING_HIZ) || (r.ir == sbt_pkg::IR_SAMPLE_HIZ) ||
              (r.ir == sbt_pkg::IR_SAMPLE);
    insIdx  = selRing ? 7'(CHAIN_LEN - 1) : 7'(sbt_pkg::ID_WIDTH - 1);
    if (r.st == sbt_pkg::ST_SHIR) begin
      serialOut = r.irShift[0];
    end else if (selRing || r.ir == sbt_pkg::IR_IDENT) begin
      serialOut = r.dr[0];
    end else begin
      serialOut = r.skip;
    end
  end

  // Controller and shift paths, all on the rising edge
  always_comb begin
    next_r = r;
    // Standard controller walk; five high samples always end in reset
    case (r.st)
      sbt_pkg::ST_TLR:   next_r.st = tms ? sbt_pkg::ST_TLR   : sbt_pkg::ST_RTI;
      sbt_pkg::ST_RTI:   next_r.st = tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_RTI;
      sbt_pkg::ST_SELDR: next_r.st = tms ? sbt_pkg::ST_SELIR : sbt_pkg::ST_CAPDR;
      sbt_pkg::ST_CAPDR: next_r.st = tms ? sbt_pkg::ST_EX1DR : sbt_pkg::ST_SHDR;
      sbt_pkg::ST_SHDR:  next_r.st = tms ? sbt_pkg::ST_EX1DR : sbt_pkg::ST_SHDR;
      sbt_pkg::ST_EX1DR: next_r.st = tms ? sbt_pkg::ST_UPDDR : sbt_pkg::ST_PDR;
      sbt_pkg::ST_PDR:   next_r.st = tms ? sbt_pkg::ST_EX2DR : sbt_pkg::ST_PDR;
      sbt_pkg::ST_EX2DR: next_r.st = tms ? sbt_pkg::ST_UPDDR : sbt_pkg::ST_SHDR;
      sbt_pkg::ST_UPDDR: next_r.st = tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_RTI;
      sbt_pkg::ST_SELIR: next_r.st = tms ? sbt_pkg::ST_TLR   : sbt_pkg::ST_CAPIR;
      sbt_pkg::ST_CAPIR: next_r.st = tms ? sbt_pkg::ST_EX1IR : sbt_pkg::ST_SHIR;
      sbt_pkg::ST_SHIR:  next_r.st = tms ? sbt_pkg::ST_EX1IR : sbt_pkg::ST_SHIR;
      sbt_pkg::ST_EX1IR: next_r.st = tms ? sbt_pkg::ST_UPDIR : sbt_pkg::ST_PIR;
      sbt_pkg::ST_PIR:   next_r.st = tms ? sbt_pkg::ST_EX2IR : sbt_pkg::ST_PIR;
      sbt_pkg::ST_EX2IR: next_r.st = tms ? sbt_pkg::ST_UPDIR : sbt_pkg::ST_SHIR;
      sbt_pkg::ST_UPDIR: next_r.st = tms ? sbt_pkg::ST_SELDR : sbt_pkg::ST_RTI;
      default:           next_r.st = sbt_pkg::ST_TLR;
    endcase

    // Actions of the present state
    case (r.st)
      sbt_pkg::ST_TLR: begin
        next_r.ir = sbt_pkg::IR_RESET;
      end
      sbt_pkg::ST_CAPIR: begin
        next_r.irShift = sbt_pkg::IR_CAPTURE;
      end
      sbt_pkg::ST_SHIR: begin
        next_r.irShift = {tdi, r.irShift[sbt_pkg::IR_WIDTH-1:1]};
      end
      sbt_pkg::ST_UPDIR: begin
        next_r.ir = r.irShift;
      end
      sbt_pkg::ST_CAPDR: begin
        next_r.skip = 1'b0;
        if (selRing) begin
          next_r.dr = '0;
          next_r.dr[CHAIN_LEN-1:0] = ringSync;
        end else if (r.ir == sbt_pkg::IR_IDENT) begin
          next_r.dr = '0;
          next_r.dr[sbt_pkg::ID_WIDTH-1:0] = ID_WORD;
        end
      end
      sbt_pkg::ST_SHDR: begin
        // Data in enters at the far end, lowest bit leaves first
        next_r.skip = tdi;
        next_r.dr = r.dr >> 1;
        next_r.dr[insIdx] = tdi;
      end
      default: begin
        // Update of the data path does nothing: nothing ever drives the pins
        next_r.skip = r.skip;
      end
    endcase
    next_r.outOff = (next_r.ir == sbt_pkg::IR_RING_HIZ) ||
                    (next_r.ir == sbt_pkg::IR_SAMPLE_HIZ);
  end

  // Link-domain state register
  always_ff @(posedge tck) begin
    if (!tapRstn) begin
      r.st      <= sbt_pkg::ST_TLR;
      r.ir      <= sbt_pkg::IR_RESET;
      r.irShift <= sbt_pkg::IR_CAPTURE;
      r.dr      <= '0;
      r.skip    <= 1'b0;
      r.outOff  <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Output changes on the falling edge so the tester samples it a half cycle later
  always_ff @(negedge tck) begin
    if (!tapRstn) begin
      tdo    <= 1'b0;
      tdoOen <= 1'b1;
    end else begin
      tdo    <= serialOut;
      tdoOen <= !((r.st == sbt_pkg::ST_SHIR) || (r.st == sbt_pkg::ST_SHDR));
    end
  end

  // Checks on the link domain
  sequence identCapture;
    r.st == sbt_pkg::ST_CAPDR && r.ir == sbt_pkg::IR_IDENT;
  endsequence

  sequence ringCapture;
    r.st == sbt_pkg::ST_CAPDR && selRing;
  endsequence

  tms_reset_a: assert property (@(posedge tck) disable iff (!tapRstn)
    tms [*5] |=> r.st == sbt_pkg::ST_TLR)
    else $error("five high mode samples did not reach reset");

  reset_ir_a: assert property (@(posedge tck) disable iff (!tapRstn)
    r.st == sbt_pkg::ST_TLR |=> r.ir == sbt_pkg::IR_IDENT)
    else $error("reset state did not load identity instruction");

  capture_ir_a: assert property (@(posedge tck) disable iff (!tapRstn)
    r.st == sbt_pkg::ST_CAPIR |=> r.irShift[1:0] == 2'h1)
    else $error("instruction capture pattern wrong");

  update_ir_a: assert property (@(posedge tck) disable iff (!tapRstn)
    r.st != sbt_pkg::ST_UPDIR && r.st != sbt_pkg::ST_TLR |=> $stable(r.ir))
    else $error("instruction changed outside update");

  ident_word_a: assert property (@(posedge tck) disable iff (!tapRstn)
    identCapture |=> r.dr[0] == sbt_pkg::ID_PRESENT &&
    r.dr[sbt_pkg::ID_REV_LSB +: 4] == REV_CODE &&
    r.dr[sbt_pkg::ID_DEPTH_LSB +: 5] == DEPTH_CODE &&
    r.dr[sbt_pkg::ID_WIDTH_LSB +: 5] == WIDTH_CODE &&
    r.dr[sbt_pkg::ID_DEV_LSB +: 6] == DEV_CODE &&
    r.dr[sbt_pkg::ID_VENDOR_LSB +: 11] == VENDOR)
    else $error("identity word captured wrong");

  ring_capture_a: assert property (@(posedge tck) disable iff (!tapRstn)
    ringCapture |=> r.dr[CHAIN_LEN-1:0] == $past(ringSync))
    else $error("pin ring not captured");

  skip_shift_a: assert property (@(posedge tck) disable iff (!tapRstn)
    r.st == sbt_pkg::ST_SHDR ##1 r.st == sbt_pkg::ST_SHDR && r.ir == sbt_pkg::IR_SKIP
    |-> serialOut == $past(tdi))
    else $error("skip bit did not pass data");

  ring_shift_a: assert property (@(posedge tck) disable iff (!tapRstn)
    r.st == sbt_pkg::ST_SHDR && selRing |=> r.dr[0] == $past(r.dr[1]) &&
    r.dr[CHAIN_LEN-1] == $past(tdi))
    else $error("chain did not shift by one");

  float_out_a: assert property (@(posedge tck) disable iff (!tapRstn)
    (r.ir == sbt_pkg::IR_SAMPLE_HIZ || r.ir == sbt_pkg::IR_RING_HIZ) |-> r.outOff)
    else $error("float request missing");
endmodule

//--- tb_sbt_tap.sv
`timescale 1ns/1ps
module tb_sbt_tap;
  localparam int CL = 70;
  // Identity fields, values arbitrary; revision and vendor set here, the rest default
  localparam logic [31:0] ID_EXP = {4'h6, 5'h0A, 5'h05, 6'h00, 11'h35A, 1'b1};
  logic        core_clk;
  logic        resetn;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdoOen;
  logic [69:0] ringIn;
  logic        memOutputsOff;
  int          nFail;
  int          nTests;

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  sbt_tap #(.CHAIN_LEN(CL), .REV_CODE(4'h6), .VENDOR(11'h35A)) uut (
    .core_clk(core_clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOen(tdoOen), .ringIn(ringIn), .memOutputsOff(memOutputsOff));

  sbt_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Load an instruction; the captured bits must come out first
  task automatic loadIr(input logic [2:0] code);
    logic [79:0] d;
    host.scan(1'b1, 3, {77'h0, code}, d);
    chk("ir capture", 80'h1, {77'h0, d[2:0]});
    // Float flag crosses into the memory domain in a few cycles
    repeat (5) @(posedge core_clk);
  endtask

  task automatic readId();
    logic [79:0] d;
    host.scan(1'b0, 32, 80'h0, d);
    chk("identity word", {48'h0, ID_EXP}, {48'h0, d[31:0]});
    chk("outputs on", 80'h0, {79'h0, memOutputsOff});
  endtask

  // Chain codes: capture, length, float
  task automatic tChain();
    logic [79:0] d;
    logic [2:0]  code;
    for (int k = 0; k < 3; k++) begin
      code = 3'(k * 2);
      @(posedge core_clk);
      #2;
      ringIn = {7{10'h2D3}} >> k;
      loadIr(code);
      host.scan(1'b0, CL + 4, 80'h9, d);
      chk("chain capture", {10'h0, ringIn}, {10'h0, d[CL-1:0]});
      chk("chain length", 80'h9, {76'h0, d[CL+3:CL]});
      chk("outputs off", {79'h0, code != 3'h4}, {79'h0, memOutputsOff});
    end
  endtask

  // Skip path with four data patterns; reserved codes are never loaded
  task automatic tSkip();
    logic [79:0] d;
    logic [7:0]  pat;
    for (int k = 0; k < 4; k++) begin
      pat = 8'hA5 >> k;
      loadIr(3'h7);
      host.scan(1'b0, 9, {72'h0, pat}, d);
      chk("skip path", {71'h0, pat, 1'b0}, {71'h0, d[8:0]});
      chk("outputs on", 80'h0, {79'h0, memOutputsOff});
    end
  endtask

  // Data out is driven only while shifting; looked at after the falling edge settles
  task automatic tEnable();
    host.moves(8'h01, 3);
    #1;
    chk("shift enable", 80'h0, {79'h0, tdoOen});
    host.moves(8'h03, 3);
    #1;
    chk("idle enable", 80'h1, {79'h0, tdoOen});
  endtask

  initial begin
    resetn = 1'b0;
    ringIn = '0;
    nFail = 0;
    nTests = 0;
    // Link clock must run while reset is held
    fork
      repeat (6) @(posedge core_clk);
      host.tapReset(12);
    join
    @(posedge core_clk);
    #2 resetn = 1'b1;
    host.tapReset(3);
    host.moves(8'h00, 1);
    #1;
    chk("idle enable", 80'h1, {79'h0, tdoOen});
    tEnable();
    readId();
    loadIr(3'h1);
    readId();
    tChain();
    tSkip();
    loadIr(3'h7);
    host.tapReset(5);
    host.moves(8'h00, 1);
    readId();
    endOfTest();
  end

  // Whole run needs well under this span
  initial begin
    #100000;
    nFail++;
    $display("mismatch watchdog expected done seen hang");
    endOfTest();
  end
endmodule
